// ### core/dce_crc16.sv
/*
 * One byte step of the CCITT CRC, data taken least significant bit first.
 * Assumes the caller holds the accumulator and presents one byte per
 * enable.
 */
`timescale 1ns/1ps
`include "dce_regs.svh"

module dce_crc16 (
    input  wire dce_pkg::dce_crc_t  crc_in,
    input  wire dce_pkg::dce_byte_t data_in,
    output dce_pkg::dce_crc_t       crc_out
);
    import dce_pkg::*;

    // ==========================================================
    // Bitwise update
    always_comb begin
        logic [15:0] acc;
        logic        fb;
        acc = crc_in;
        fb  = 1'b0;
        // R3 LSB enters first
        for (int i = 0; i < 8; i++) begin
            fb  = acc[15] ^ data_in[i];
            // R1 CCITT polynomial step
            acc = {acc[14:0], 1'b0} ^ (fb ? `DCE_CRC_POLY : 16'h0000);
        end
        crc_out = acc;
    end

endmodule : dce_crc16

// ### core/dce_executor.sv
/*
 * Command executor of the on-chip debugger. Takes command and operand
 * bytes from the debug line receiver, runs the program memory CRC,
 * step, stuff and execute commands, and holds the line control register.
 * Assumes the serial front end, program memory and CPU share ref_clk;
 * the memory answers one cycle after a read; the CPU reports the
 * length of an instruction from its first byte.
 */
`timescale 1ns/1ps
`include "dce_regs.svh"

module dce_executor #(
    parameter int PM_BYTES = 24576,
    parameter int PM_AW    = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               rx_valid,
    input  wire dce_pkg::dce_byte_t rx_byte,
    output logic                    tx_valid,
    output dce_pkg::dce_byte_t      tx_byte,
    input  wire logic               tx_ready,
    input  wire logic               tx_active,
    input  wire logic               tx_level,
    output logic                    debug_serial_pin_o,
    output logic                    debug_serial_pin_oe,
    output logic                    high_drive_select,
    output logic                    ninth_bit_enable,
    output logic                    ninth_bit_value,
    output logic                    tx_flow_ctrl,
    output logic                    tx_drive_high,
    input  wire logic               debug_mode,
    input  wire logic               read_protect,
    output logic                    pm_rd,
    output logic [PM_AW-1:0]        pm_addr,
    input  wire dce_pkg::dce_byte_t pm_data,
    output logic                    step_req,
    output logic                    stuff_req,
    output dce_pkg::dce_byte_t      stuff_opcode,
    output logic                    exec_req,
    output logic [39:0]             exec_instr,
    output logic [2:0]              exec_len,
    input  wire logic [2:0]         op_len,
    input  wire logic               cpu_busy
);
    import dce_pkg::*;

    localparam logic [PM_AW-1:0] PM_LAST = PM_AW'(PM_BYTES - 1);

    dce_state_e      state;
    dce_byte_t       cmd;
    dce_byte_t       line_ctrl;
    dce_crc_t        crc;
    dce_crc_t        next_crc;
    dce_crc_t        reply;
    logic            reply_two;
    logic            crc_data_vld;
    logic [2:0]      collect_cnt;
    logic [2:0]      collect_len;
    logic [39:0]     collect_buf;
    logic            allowed;

    // R7 debug mode and no protection
    assign allowed = debug_mode & ~read_protect;

    // ==========================================================
    // Command sequencing
    // R16 command byte then operands
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= DCE_IDLE;
            cmd   <= 8'h00;
        end else begin
            unique case (state)
                DCE_IDLE: begin
                    if (rx_valid) begin
                        cmd <= rx_byte;
                        unique case (rx_byte)
                            `DCE_CMD_CRC: begin
                                // R5 outside debug answer at once
                                if (debug_mode) begin
                                    state <= DCE_CRC_RUN;
                                end else begin
                                    state <= DCE_REPLY;
                                end
                            end
                            `DCE_CMD_STUFF,
                            `DCE_CMD_EXEC,
                            `DCE_CMD_LC_WR: begin
                                state <= DCE_OPERAND;
                            end
                            `DCE_CMD_LC_RD: begin
                                state <= DCE_REPLY;
                            end
                            default: begin
                                state <= DCE_IDLE;
                            end
                        endcase
                    end
                end
                DCE_OPERAND: begin
                    if (rx_valid) begin
                        if (cmd == `DCE_CMD_EXEC &&
                            op_len > `DCE_INSTR_MIN) begin
                            state <= DCE_COLLECT;
                        end else begin
                            state <= DCE_IDLE;
                        end
                    end
                end
                DCE_COLLECT: begin
                    // R9 collect all instruction bytes
                    if (rx_valid && collect_cnt == collect_len) begin
                        state <= DCE_IDLE;
                    end
                end
                DCE_CRC_RUN: begin
                    if (pm_addr == PM_LAST) begin
                        state <= DCE_CRC_DRAIN;
                    end
                end
                DCE_CRC_DRAIN: begin
                    // R6 reply after last byte
                    if (!crc_data_vld) begin
                        state <= DCE_REPLY;
                    end
                end
                DCE_REPLY: begin
                    if (tx_ready && !reply_two) begin
                        state <= DCE_IDLE;
                    end
                end
                default: begin
                    state <= DCE_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Program memory scan
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pm_addr      <= '0;
            crc_data_vld <= 1'b0;
        end else begin
            crc_data_vld <= pm_rd;
            if (state == DCE_IDLE) begin
                pm_addr <= '0;
            end else if (pm_rd && pm_addr != PM_LAST) begin
                pm_addr <= pm_addr + 1'b1;
            end
        end
    end

    // R6 one byte per clock
    assign pm_rd = (state == DCE_CRC_RUN);

    // ==========================================================
    // CRC accumulator
    dce_crc16 u_crc (
        .crc_in  (crc),
        .data_in (pm_data),
        .crc_out (next_crc)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            crc <= `DCE_CRC_INIT;
        end else if (state == DCE_IDLE) begin
            // R2 preset to ones
            crc <= `DCE_CRC_INIT;
        end else if (crc_data_vld) begin
            // R1 fold in memory byte
            crc <= next_crc;
        end
    end

    // ==========================================================
    // Reply bytes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reply     <= 16'h0000;
            reply_two <= 1'b0;
        end else if (state == DCE_IDLE && rx_valid) begin
            if (rx_byte == `DCE_CMD_CRC) begin
                // R5 fixed answer outside debug
                reply     <= `DCE_CRC_NODEBUG;
                reply_two <= 1'b1;
            end else begin
                // R11 line control readback
                reply     <= {line_ctrl, 8'h00};
                reply_two <= 1'b0;
            end
        end else if (state == DCE_CRC_DRAIN && !crc_data_vld) begin
            // R4 complemented result
            reply     <= ~crc;
            reply_two <= 1'b1;
        end else if (state == DCE_REPLY && tx_ready) begin
            // R4 high byte first
            reply     <= {reply[7:0], 8'h00};
            reply_two <= 1'b0;
        end
    end

    assign tx_valid = (state == DCE_REPLY);
    assign tx_byte  = reply[15:8];

    // ==========================================================
    // Instruction collection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            collect_cnt <= 3'h0;
            collect_len <= 3'h0;
            collect_buf <= 40'h0;
        end else if (rx_valid) begin
            if (state == DCE_OPERAND) begin
                collect_buf <= {rx_byte, 32'h0};
                collect_cnt <= 3'h2;
                // R9 length from opcode
                if (op_len > `DCE_INSTR_MAX) begin
                    collect_len <= `DCE_INSTR_MAX;
                end else begin
                    collect_len <= op_len;
                end
            end else if (state == DCE_COLLECT) begin
                collect_buf <= collect_buf |
                    (40'(rx_byte) << (6'(`DCE_INSTR_MAX - collect_cnt)
                                      * 6'h08));
                collect_cnt <= collect_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // CPU requests
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            step_req     <= 1'b0;
            stuff_req    <= 1'b0;
            stuff_opcode <= 8'h00;
            exec_req     <= 1'b0;
            exec_instr   <= 40'h0;
            exec_len     <= 3'h0;
        end else begin
            step_req  <= 1'b0;
            stuff_req <= 1'b0;
            exec_req  <= 1'b0;
            // R7 single step when allowed
            if (state == DCE_IDLE && rx_valid &&
                rx_byte == `DCE_CMD_STEP && allowed && !cpu_busy) begin
                step_req <= 1'b1;
            end
            // R8 stuff first byte
            if (state == DCE_OPERAND && rx_valid &&
                cmd == `DCE_CMD_STUFF && allowed && !cpu_busy) begin
                stuff_req    <= 1'b1;
                stuff_opcode <= rx_byte;
            end
            // R9 one byte instruction
            if (state == DCE_OPERAND && rx_valid &&
                cmd == `DCE_CMD_EXEC && op_len <= `DCE_INSTR_MIN &&
                allowed && !cpu_busy) begin
                exec_req   <= 1'b1;
                exec_instr <= {rx_byte, 32'h0};
                exec_len   <= `DCE_INSTR_MIN;
            end
            // R9 multi byte instruction
            if (state == DCE_COLLECT && rx_valid &&
                collect_cnt == collect_len && allowed && !cpu_busy) begin
                exec_req   <= 1'b1;
                exec_instr <= collect_buf |
                    (40'(rx_byte) << (6'(`DCE_INSTR_MAX - collect_cnt)
                                      * 6'h08));
                exec_len   <= collect_len;
            end
        end
    end

    // ==========================================================
    // Line control register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            // R15 reset to zero
            line_ctrl <= `DCE_LC_RESET;
        end else if (state == DCE_OPERAND && rx_valid &&
                     cmd == `DCE_CMD_LC_WR) begin
            // R10 load data byte
            // R15 top bits stay zero
            line_ctrl <= rx_byte & `DCE_LC_WMASK;
        end
    end

    // R12 ninth bit controls
    assign ninth_bit_enable  = line_ctrl[`DCE_LC_NB_EN];
    assign ninth_bit_value   = line_ctrl[`DCE_LC_NB_EN] &
                               line_ctrl[`DCE_LC_NB_VAL];
    // R14 drive strength
    assign high_drive_select = line_ctrl[`DCE_LC_HIGH_DRV];
    assign tx_flow_ctrl      = line_ctrl[`DCE_LC_FLOW];
    assign tx_drive_high     = line_ctrl[`DCE_LC_DRV_HIGH];

    // ==========================================================
    // Debug pin driver
    // R13 open drain or push pull
    assign debug_serial_pin_o  = tx_level;
    assign debug_serial_pin_oe = tx_active &
                                 (line_ctrl[`DCE_LC_PUSH_PULL] | ~tx_level);

endmodule : dce_executor

// ### include/dce_pkg.sv
/*
 * Types of the debug command executor.
 * Assumes dce_regs.svh is available on the include path.
 */
package dce_pkg;

    // ==========================================================
    // Types
    typedef logic [7:0]  dce_byte_t;
    typedef logic [15:0] dce_crc_t;

    typedef enum logic [2:0] {
        DCE_IDLE,
        DCE_OPERAND,
        DCE_COLLECT,
        DCE_CRC_RUN,
        DCE_CRC_DRAIN,
        DCE_REPLY
    } dce_state_e;

endpackage : dce_pkg

// ### include/dce_regs.svh
/*
 * Constants of the debug command executor: command codes, line control
 * field positions, reset values and CRC figures.
 * Assumes it is included once per compilation unit by its bare name.
 */
// Notes on behaviour
// R1: Command 0EH computes a 16-bit CCITT CRC over all program memory.
// R2: The CRC accumulator starts at all ones.
// R3: Each memory byte enters the CRC least significant bit first.
// R4: The complemented CRC is sent, high byte then low byte.
// R5: Outside debug mode the CRC command answers FFFFH.
// R6: The CRC answer comes after about one clock per memory byte.
// R7: Command 10H steps one instruction; ignored outside debug or protected.
// R8: Command 11H takes an opcode; rest of instruction from memory.
// R9: Command 12H takes a whole 1-5 byte instruction and executes it.
// R10: Command 18H loads the following byte into line control.
// R11: Command 19H returns the line control contents.
// R12: Line control bit 4 enables ninth bit; bit 5 gives its value.
// R13: Line control bit 1: 0 open-drain low only, 1 both levels.
// R14: Line control bit 0 selects low or high drive strength.
// R15: Line control bits 7:6 read zero, unwritable; all reset to zero.
// R16: Command byte first, operands in order, replies after completion.
`ifndef DCE_REGS_SVH
`define DCE_REGS_SVH

// ==========================================================
// Command codes
`define DCE_CMD_CRC       8'h0e
`define DCE_CMD_STEP      8'h10
`define DCE_CMD_STUFF     8'h11
`define DCE_CMD_EXEC      8'h12
`define DCE_CMD_LC_WR     8'h18
`define DCE_CMD_LC_RD     8'h19

// ==========================================================
// Line control fields
`define DCE_LC_RESET      8'h00
`define DCE_LC_WMASK      8'h3f
`define DCE_LC_NB_VAL     5
`define DCE_LC_NB_EN      4
`define DCE_LC_FLOW       3
`define DCE_LC_DRV_HIGH   2
`define DCE_LC_PUSH_PULL  1
`define DCE_LC_HIGH_DRV   0

// ==========================================================
// CRC figures
`define DCE_CRC_INIT      16'hffff
`define DCE_CRC_POLY      16'h1021
`define DCE_CRC_NODEBUG   16'hffff

// ==========================================================
// Instruction limits
`define DCE_INSTR_MAX     3'h5
`define DCE_INSTR_MIN     3'h1

`endif

// ### verification/dce_executor_sva.sv
/* Checker for the debug command executor, bound to dce_executor.
   Assumes only the ports of dce_executor are visible. */
`timescale 1ns/1ps
`include "dce_regs.svh"

module dce_executor_sva #(
    parameter int PM_BYTES = 24576,
    parameter int PM_AW    = 16
) (
    input wire logic               ref_clk,
    input wire logic               rstn,
    input wire logic               rx_valid,
    input wire dce_pkg::dce_byte_t rx_byte,
    input wire logic               tx_valid,
    input wire dce_pkg::dce_byte_t tx_byte,
    input wire logic               tx_ready,
    input wire logic               tx_active,
    input wire logic               tx_level,
    input wire logic               debug_serial_pin_o,
    input wire logic               debug_serial_pin_oe,
    input wire logic               ninth_bit_enable,
    input wire logic               ninth_bit_value,
    input wire logic               debug_mode,
    input wire logic               read_protect,
    input wire logic               pm_rd,
    input wire logic [PM_AW-1:0]   pm_addr,
    input wire logic               step_req,
    input wire logic               stuff_req
);
    import dce_pkg::*;
    int scan_cnt;

    // ==========================================================
    // Scan length counter
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scan_cnt <= 0;
        end else begin
            scan_cnt <= pm_rd ? scan_cnt + 1 : 0;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_step_cause: assert property (step_req |-> $past(rx_valid
        && rx_byte == `DCE_CMD_STEP && debug_mode && !read_protect))
        else $error("step request without cause");
    a_step_single: assert property (step_req |=> !step_req)
        else $error("step request longer than one cycle");
    a_stuff_cause: assert property (stuff_req |-> $past(rx_valid)
        && $past(debug_mode && !read_protect))
        else $error("stuff request without cause");
    a_reply_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_byte))
        else $error("reply byte dropped before taken");
    a_pin_low_drive: assert property (tx_active && !tx_level |->
        debug_serial_pin_oe && !debug_serial_pin_o)
        else $error("low bit not driven");
    a_pin_idle_off: assert property (!tx_active |->
        !debug_serial_pin_oe)
        else $error("pin driven outside transmission");
    a_ninth_gate: assert property (ninth_bit_value |->
        ninth_bit_enable)
        else $error("ninth bit value while mode off");
    a_scan_start: assert property ($rose(pm_rd) |-> pm_addr == 0)
        else $error("scan does not start at zero");
    a_scan_step: assert property (pm_rd && $past(pm_rd) |->
        pm_addr == $past(pm_addr) + 1'b1)
        else $error("scan address skipped");
    a_scan_len: assert property ($fell(pm_rd) |->
        scan_cnt == PM_BYTES)
        else $error("scan length wrong");

    c_step: cover property (step_req);
    c_scan: cover property ($fell(pm_rd));
    c_reply: cover property (tx_valid && tx_ready);
endmodule : dce_executor_sva

bind dce_executor dce_executor_sva #(.PM_BYTES(PM_BYTES), .PM_AW(PM_AW))
    u_sva (.ref_clk, .rstn, .rx_valid, .rx_byte, .tx_valid, .tx_byte,
    .tx_ready, .tx_active, .tx_level, .debug_serial_pin_o,
    .debug_serial_pin_oe, .ninth_bit_enable, .ninth_bit_value, .debug_mode,
    .read_protect, .pm_rd, .pm_addr, .step_req, .stuff_req);

// ### verification/dce_host_model.sv
/* Debug host side: takes reply bytes, shifts them out LSB first.
   Assumes the executor offers bytes on tx_valid and tx_byte. */
`timescale 1ns/1ps

module dce_host_model (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               tx_valid,
    input  wire dce_pkg::dce_byte_t tx_byte,
    output logic                    tx_ready,
    output logic                    tx_active,
    output logic                    tx_level
);
    import dce_pkg::*;
    int        gap = 0;
    int        wait_cnt;
    int        bits;
    dce_byte_t shift;
    dce_byte_t got[$];

    // ==========================================================
    // Reply intake and line shifting
    // wait, take in order
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ready  <= 1'b0;
            tx_active <= 1'b0;
            tx_level  <= 1'b1;
            wait_cnt  <= 0;
            bits      <= 0;
        end else begin
            tx_ready  <= 1'b0;
            tx_active <= bits != 0;
            tx_level  <= bits != 0 ? shift[0] : 1'b1;
            if (bits != 0) begin
                shift <= shift >> 1;
                bits  <= bits - 1;
            end else if (tx_valid && !tx_ready) begin
                if (wait_cnt >= gap) begin
                    tx_ready <= 1'b1;
                    got.push_back(tx_byte);
                    shift    <= tx_byte;
                    bits     <= 8;
                    wait_cnt <= 0;
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end
        end
    end
endmodule : dce_host_model

// ### verification/debug_command_executor_bench.sv
/* Bench for dce_executor with the host model and an 8 byte memory.
   Assumes PM_BYTES is set to 8 here. */
`timescale 1ns/1ps
`include "dce_regs.svh"

module debug_command_executor_bench;
    import dce_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        rx_valid = 1'b0;
    dce_byte_t   rx_byte = 8'h00;
    logic        debug_mode = 1'b0;
    logic        read_protect = 1'b0;
    logic        cpu_busy = 1'b0;
    dce_byte_t   pm_data = 8'h00;
    logic [2:0]  op_len;
    logic        tx_valid, tx_ready, tx_active, tx_level, pm_rd;
    logic        debug_serial_pin_o, debug_serial_pin_oe, high_drive_select;
    logic        ninth_bit_enable, ninth_bit_value, step_req, stuff_req;
    logic        exec_req, tx_flow_ctrl, tx_drive_high;
    logic [3:0]  pin_obs;
    logic [4:0]  lc_out;
    dce_byte_t   tx_byte, stuff_opcode, got_op;
    logic [15:0] pm_addr;
    logic [39:0] exec_instr, got_ins;
    logic [2:0]  exec_len, got_len;
    dce_byte_t   mem [8] = '{8'h3c, 8'h00, 8'hff, 8'h81,
                             8'h5a, 8'h01, 8'h80, 8'hc3};
    int          failures = 0, check_count = 0, cyc = 0;
    int          n_step = 0, n_stuff = 0, n_exec = 0;

    assign op_len = rx_byte[2:0];
    assign pin_obs = {tx_active, tx_level, debug_serial_pin_o,
                      debug_serial_pin_oe};
    assign lc_out = {high_drive_select, ninth_bit_enable, ninth_bit_value,
                     tx_flow_ctrl, tx_drive_high};
    always #50 ref_clk = ~ref_clk;

    dce_executor #(.PM_BYTES(8)) dut (.ref_clk, .rstn, .rx_valid, .rx_byte,
        .tx_valid, .tx_byte, .tx_ready, .tx_active, .tx_level,
        .debug_serial_pin_o, .debug_serial_pin_oe, .high_drive_select,
        .ninth_bit_enable, .ninth_bit_value, .tx_flow_ctrl,
        .tx_drive_high, .debug_mode, .read_protect, .pm_rd, .pm_addr,
        .pm_data, .step_req, .stuff_req, .stuff_opcode, .exec_req,
        .exec_instr, .exec_len, .op_len, .cpu_busy);

    dce_host_model host (.ref_clk, .rstn, .tx_valid, .tx_byte, .tx_ready,
        .tx_active, .tx_level);

    // ==========================================================
    // Memory, pulse capture and timeout
    always @(posedge ref_clk) begin
        pm_data <= mem[pm_addr[2:0]];
        cyc <= cyc + 1;
        n_step <= n_step + step_req;
        n_stuff <= n_stuff + stuff_req;
        n_exec <= n_exec + exec_req;
        if (stuff_req) got_op <= stuff_opcode;
        if (exec_req) begin
            got_ins <= exec_instr;
            got_len <= exec_len;
        end
        if (cyc == 3000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task check(input logic [39:0] seen, input logic [39:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            failures = failures + 1;
        end
    endtask : check

    task send(input dce_byte_t b);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
    endtask : send

    task get(output dce_byte_t b);
        for (int k = 0; k < 300 && host.got.size() == 0; k++)
            @(posedge ref_clk);
        b = host.got.size() != 0 ? host.got.pop_front() : 8'hxx;
    endtask : get

    task chk_oe(input logic exp);
        for (int k = 0; k < 20 && !(tx_active && tx_level); k++)
            @(negedge ref_clk);
        check(pin_obs, {3'b111, exp});
    endtask : chk_oe

    // ==========================================================
    // Scenarios
    task t_lc;
        dce_byte_t b;
        send(`DCE_CMD_LC_RD);
        get(b);
        check(b, 8'h00);
        send(`DCE_CMD_LC_WR);
        send(8'hff);
        send(`DCE_CMD_LC_RD);
        get(b);
        check(b, 8'h3f);
        check(lc_out, 5'h1f);
        chk_oe(1'b1);
        send(`DCE_CMD_LC_WR);
        send(8'h20);
        send(`DCE_CMD_LC_RD);
        get(b);
        check(b, 8'h20);
        check(lc_out, 5'h00);
        chk_oe(1'b0);
    endtask : t_lc

    task t_crc;
        dce_byte_t h, l;
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < 8; i++)
            for (int j = 0; j < 8; j++)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][j]) ? 16'h1021 : 0);
        c = ~c;
        host.gap = 5;
        debug_mode <= 1'b1;
        send(`DCE_CMD_CRC);
        get(h);
        get(l);
        check({h, l}, c);
        debug_mode <= 1'b0;
        send(`DCE_CMD_CRC);
        get(h);
        get(l);
        check({h, l}, 16'hffff);
        host.gap = 0;
    endtask : t_crc

    task t_cmd;
        dce_byte_t b;
        send(`DCE_CMD_STEP);
        debug_mode <= 1'b1;
        send(`DCE_CMD_STEP);
        send(`DCE_CMD_STUFF);
        send(8'h5c);
        send(`DCE_CMD_EXEC);
        send(8'h03);
        send(8'ha5);
        send(8'h3c);
        repeat (2) @(posedge ref_clk);
        check({n_step[3:0], n_stuff[3:0], n_exec[3:0]}, 12'h111);
        check(got_op, 8'h5c);
        check({got_ins[39:16], got_len}, {24'h03a53c, 3'h3});
        cpu_busy <= 1'b1;
        send(`DCE_CMD_STEP);
        cpu_busy <= 1'b0;
        read_protect <= 1'b1;
        send(`DCE_CMD_STEP);
        send(`DCE_CMD_STUFF);
        send(8'h07);
        send(`DCE_CMD_EXEC);
        send(8'h02);
        send(8'h99);
        send(`DCE_CMD_LC_RD);
        get(b);
        check(b, 8'h20);
        check({n_step[3:0], n_stuff[3:0], n_exec[3:0]}, 12'h111);
        read_protect <= 1'b0;
    endtask : t_cmd

    task finish_test;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        t_lc();
        t_crc();
        t_cmd();
        finish_test();
    end
endmodule : debug_command_executor_bench
